// ===== design/dcmc_pkg.sv
// dual clock mode controller: shared constants, mode codes and gate decode
// assumes one 200 MHz clock and an asynchronous active-high reset
`default_nettype none
package dcmc_pkg;
    // =========================================================
    // counts, reset values, synchroniser slots
    localparam int   WARM_W            = 16;
    localparam int   WARMUP_CYCLES_DEF = 16384;
    localparam logic MSEL_RST          = 1'b0;
    localparam logic FOSC_RST          = 1'b1;
    localparam logic SOSC_RST          = 1'b0;
    localparam logic HALT_RST          = 1'b0;
    localparam logic RELM_RST          = 1'b0;
    localparam logic PIN_RST           = 1'b0;
    localparam logic [7:0] GATE_RST    = 8'h9F;
    localparam int   SYNC_STOP         = 0;
    localparam int   SYNC_TICK         = 1;
    localparam int   SYNC_N            = 2;

    // =========================================================
    // mode codes and gate set
    typedef enum logic [3:0] {
        FAST_SINGLE_RUN  = 4'h0,
        FAST_DUAL_RUN    = 4'h1,
        SLOW_DUAL_RUN    = 4'h3,
        LOWCLK_ONLY_RUN  = 4'h2,
        LOWCLK_ONLY_DOZE = 4'h6,
        SLOW_DUAL_DOZE   = 4'h7,
        FAST_DUAL_DOZE   = 4'h5,
        TICK_ONLY_DOZE   = 4'h4,
        STOP_HALT        = 4'hC,
        STOP_WARMUP      = 4'hD
    } dcmc_mode_t;

    typedef struct packed {
        logic fosc_on;
        logic sosc_on;
        logic cpu_slow;
        logic cpu_en;
        logic wdt_en;
        logic tick_en;
        logic per_en;
        logic div_early;
    } dcmc_gate_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
        logic rise;
        logic fall;
    } dcmc_sync_t;

    // =========================================================
    // decode
    function automatic dcmc_gate_t dcmc_gates(input dcmc_mode_t m);
        dcmc_gate_t g;
        g = '0;
        unique case (m)
            FAST_SINGLE_RUN:  g = 8'h9F;
            FAST_DUAL_RUN:    g = 8'hDF;
            SLOW_DUAL_RUN:    g = 8'hFF;
            LOWCLK_ONLY_RUN:  g = 8'h7E;
            FAST_DUAL_DOZE:   g = 8'hC7;
            SLOW_DUAL_DOZE:   g = 8'hE6;
            LOWCLK_ONLY_DOZE: g = 8'h66;
            TICK_ONLY_DOZE:   g = 8'h64;
            STOP_HALT:        g = 8'h00;
            STOP_WARMUP:      g = 8'h00;
            default:          g = 8'h00;
        endcase
        return g;
    endfunction

    function automatic logic dcmc_is_run(input dcmc_mode_t m);
        return m == FAST_SINGLE_RUN || m == FAST_DUAL_RUN
            || m == SLOW_DUAL_RUN || m == LOWCLK_ONLY_RUN;
    endfunction
endpackage
`default_nettype wire

// ===== design/dcmc_sync_if.sv
// dual clock mode controller: carrier between a pin and its synchroniser
// assumes the synchroniser and its user share clk_i
`timescale 1ns/1ps
`default_nettype none
interface dcmc_sync_if;
    logic raw;
    logic level;
    logic rise;
    logic fall;
    modport pin  (output raw, input level, input rise, input fall);
    modport sync (input raw, output level, output rise, output fall);
endinterface
`default_nettype wire

// ===== design/dcmc_pin_sync.sv
// dual clock mode controller: three-flop pin synchroniser with edge pulses
// assumes raw comes from outside the clk_i domain
`timescale 1ns/1ps
`default_nettype none
module dcmc_pin_sync (
    input  wire logic   clk_i,
    input  wire logic   sys_rst_i,
    dcmc_sync_if.sync   port
);
    import dcmc_pkg::*;

    dcmc_sync_t q;
    dcmc_sync_t d;

    // =========================================================
    // filter: a change counts once flops two and three agree
    always_comb begin
        d      = q;
        d.s1   = port.raw;
        d.s2   = q.s1;
        d.s3   = q.s2;
        d.rise = 1'b0;
        d.fall = 1'b0;
        if (q.s2 == q.s3 && q.s3 != q.lvl) begin
            d.lvl  = q.s3;
            d.rise = q.s3;
            d.fall = ~q.s3;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            q <= '{PIN_RST, PIN_RST, PIN_RST, PIN_RST, 1'b0, 1'b0};
        end else begin
            q <= d;
        end
    end

    assign port.level = q.lvl;
    assign port.rise  = q.rise;
    assign port.fall  = q.fall;
endmodule
`default_nettype wire

// ===== design/dcmc_top.sv
// dual clock mode controller: operating mode state machine and clock gates
// assumes control writes and interrupt requests are on clk_i; pins are not
`timescale 1ns/1ps
`default_nettype none
module dcmc_top #(
    parameter int WARMUP_CYCLES = dcmc_pkg::WARMUP_CYCLES_DEF
) (
    input  wire logic          clk_i,
    input  wire logic          sys_rst_i,
    input  wire logic          ctrl2_wr_i,
    input  wire logic          wr_main_clock_select_i,
    input  wire logic          wr_fast_osc_enable_i,
    input  wire logic          wr_slow_osc_enable_i,
    input  wire logic          wr_cpu_halt_i,
    input  wire logic          wr_timing_gen_halt_i,
    input  wire logic          ctrl1_wr_i,
    input  wire logic          wr_stop_i,
    input  wire logic          wr_release_level_i,
    input  wire logic          irq_request_i,
    input  wire logic          stop_pin_i,
    input  wire logic          tick_src_i,
    input  wire logic          tick_timer_enable_i,
    input  wire logic          master_interrupt_enable_i,
    input  wire logic          tick_irq_enable_i,
    output dcmc_pkg::dcmc_mode_t mode_o,
    output logic               main_clock_select_o,
    output logic               cpu_halt_o,
    output logic               timing_gen_halt_o,
    output logic               fast_osc_on_o,
    output logic               slow_osc_on_o,
    output logic               cpu_from_slow_o,
    output logic               cpu_clk_en_o,
    output logic               wdt_clk_en_o,
    output logic               tick_clk_en_o,
    output logic               periph_clk_en_o,
    output logic               div_early_en_o,
    output logic               tick_irq_set_o,
    output logic               tick_irq_take_o,
    output logic               resume_o
);
    import dcmc_pkg::*;

    typedef struct packed {
        dcmc_mode_t          mode;
        dcmc_mode_t          ret_mode;
        logic                msel;
        logic                fosc;
        logic                sosc;
        logic                cpu_halt;
        logic                tg_halt;
        logic                rel_level;
        logic                tick_armed;
        logic                irq_pend;
        logic [WARM_W-1:0]   warm_cnt;
        dcmc_gate_t          gate;
        logic                set_p;
        logic                take_p;
        logic                resume_p;
    } dcmc_state_t;

    dcmc_state_t q;
    dcmc_state_t d;
    logic        stop_req;
    logic        stop_release;
    logic        slow_run;
    dcmc_sync_if sif [SYNC_N] ();

    // =========================================================
    // pin synchronisers
    for (genvar g = 0; g < SYNC_N; g++) begin : g_sync
        dcmc_pin_sync u_sync (
            .clk_i     (clk_i),
            .sys_rst_i (sys_rst_i),
            .port      (sif[g])
        );
    end
    assign sif[SYNC_STOP].raw = stop_pin_i;
    assign sif[SYNC_TICK].raw = tick_src_i;

    // =========================================================
    // requests
    assign stop_req = ctrl1_wr_i & wr_stop_i & dcmc_is_run(q.mode);
    assign slow_run = q.mode == SLOW_DUAL_RUN || q.mode == LOWCLK_ONLY_RUN;
    assign stop_release = q.rel_level ? sif[SYNC_STOP].level
                                      : sif[SYNC_STOP].rise;

    // =========================================================
    // next state
    always_comb begin
        d          = q;
        d.set_p    = 1'b0;
        d.resume_p = 1'b0;
        d.take_p   = q.set_p & master_interrupt_enable_i & tick_irq_enable_i
                   & tick_timer_enable_i;
        if (ctrl2_wr_i) begin
            d.msel = wr_main_clock_select_i;
            d.fosc = wr_fast_osc_enable_i;
            d.sosc = wr_slow_osc_enable_i;
            if (dcmc_is_run(q.mode)) begin
                d.cpu_halt = wr_cpu_halt_i;
                d.tg_halt  = wr_timing_gen_halt_i & slow_run;
            end
        end
        if (ctrl1_wr_i) begin
            d.rel_level = wr_release_level_i;
        end
        if (q.irq_pend && q.mode == LOWCLK_ONLY_RUN) begin
            d.set_p    = 1'b1;
            d.irq_pend = 1'b0;
        end
        if (stop_req) begin
            d.mode     = STOP_HALT;
            d.ret_mode = q.mode;
        end else begin
            unique case (q.mode)
                FAST_SINGLE_RUN: begin
                    if (q.sosc) begin
                        d.mode = FAST_DUAL_RUN;
                    end
                end
                FAST_DUAL_RUN: begin
                    if (q.cpu_halt) begin
                        d.mode = FAST_DUAL_DOZE;
                    end else if (q.msel && q.fosc && q.sosc) begin
                        d.mode = SLOW_DUAL_RUN;
                    end else if (!q.sosc) begin
                        d.mode = FAST_SINGLE_RUN;
                    end
                end
                SLOW_DUAL_RUN: begin
                    if (q.tg_halt) begin
                        d.mode       = TICK_ONLY_DOZE;
                        d.tick_armed = tick_timer_enable_i;
                    end else if (q.cpu_halt) begin
                        d.mode = SLOW_DUAL_DOZE;
                    end else if (!q.msel) begin
                        d.mode = FAST_DUAL_RUN;
                    end else if (!q.fosc) begin
                        d.mode = LOWCLK_ONLY_RUN;
                    end
                end
                LOWCLK_ONLY_RUN: begin
                    if (q.tg_halt) begin
                        d.mode       = TICK_ONLY_DOZE;
                        d.tick_armed = tick_timer_enable_i;
                    end else if (q.cpu_halt) begin
                        d.mode = LOWCLK_ONLY_DOZE;
                    end else if (q.fosc) begin
                        d.mode = SLOW_DUAL_RUN;
                    end
                end
                FAST_DUAL_DOZE: begin
                    if (irq_request_i) begin
                        d.mode     = FAST_DUAL_RUN;
                        d.cpu_halt = 1'b0;
                    end
                end
                SLOW_DUAL_DOZE: begin
                    if (irq_request_i) begin
                        d.mode     = SLOW_DUAL_RUN;
                        d.cpu_halt = 1'b0;
                    end
                end
                LOWCLK_ONLY_DOZE: begin
                    if (irq_request_i) begin
                        d.mode     = LOWCLK_ONLY_RUN;
                        d.cpu_halt = 1'b0;
                    end
                end
                TICK_ONLY_DOZE: begin
                    if (sif[SYNC_TICK].fall) begin
                        d.mode     = LOWCLK_ONLY_RUN;
                        d.tg_halt  = 1'b0;
                        d.fosc     = 1'b0;
                        d.irq_pend = q.tick_armed;
                    end
                end
                STOP_HALT: begin
                    if (stop_release) begin
                        d.mode     = STOP_WARMUP;
                        d.warm_cnt = WARM_W'(WARMUP_CYCLES - 1);
                    end
                end
                STOP_WARMUP: begin
                    if (q.warm_cnt == '0) begin
                        d.mode     = q.ret_mode;
                        d.resume_p = 1'b1;
                    end else begin
                        d.warm_cnt = q.warm_cnt - 1'b1;
                    end
                end
                default: begin
                    d.mode = FAST_SINGLE_RUN;
                end
            endcase
        end
        // gates follow the next mode so outputs line up with mode_o
        d.gate = dcmc_gates(d.mode);
        if (d.mode == STOP_WARMUP) begin
            d.gate.fosc_on = dcmc_gates(d.ret_mode).fosc_on;
            d.gate.sosc_on = dcmc_gates(d.ret_mode).sosc_on;
        end
    end

    // =========================================================
    // state register
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            q            <= '0;
            q.mode       <= FAST_SINGLE_RUN;
            q.ret_mode   <= FAST_SINGLE_RUN;
            q.msel       <= MSEL_RST;
            q.fosc       <= FOSC_RST;
            q.sosc       <= SOSC_RST;
            q.cpu_halt   <= HALT_RST;
            q.tg_halt    <= HALT_RST;
            q.rel_level  <= RELM_RST;
            q.gate       <= GATE_RST;
        end else begin
            q <= d;
        end
    end

    // =========================================================
    // outputs
    assign mode_o              = q.mode;
    assign main_clock_select_o = q.msel;
    assign cpu_halt_o          = q.cpu_halt;
    assign timing_gen_halt_o   = q.tg_halt;
    assign fast_osc_on_o       = q.gate.fosc_on;
    assign slow_osc_on_o       = q.gate.sosc_on;
    assign cpu_from_slow_o     = q.gate.cpu_slow;
    assign cpu_clk_en_o        = q.gate.cpu_en;
    assign wdt_clk_en_o        = q.gate.wdt_en;
    assign tick_clk_en_o       = q.gate.tick_en;
    assign periph_clk_en_o     = q.gate.per_en;
    assign div_early_en_o      = q.gate.div_early;
    assign tick_irq_set_o      = q.set_p;
    assign tick_irq_take_o     = q.take_p;
    assign resume_o            = q.resume_p;

    // =========================================================
    // checks
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    a_slow_entry: assert property (
        mode_o == FAST_DUAL_RUN && q.msel && q.fosc && q.sosc && !q.cpu_halt
        && !stop_req |=> mode_o == SLOW_DUAL_RUN && cpu_from_slow_o)
        else $error("slow dual run not entered");

    a_fast_return: assert property (
        mode_o == SLOW_DUAL_RUN && !q.msel && !q.tg_halt && !q.cpu_halt
        && !stop_req |=> mode_o == FAST_DUAL_RUN && !cpu_from_slow_o)
        else $error("fast dual run not entered");

    a_fast_osc_off: assert property (
        mode_o == SLOW_DUAL_RUN && q.msel && !q.fosc && !q.tg_halt
        && !q.cpu_halt && !stop_req |=> !fast_osc_on_o ##1 !fast_osc_on_o)
        else $error("fast oscillator still on");

    a_lowclk_gates: assert property (
        mode_o == LOWCLK_ONLY_RUN |-> !fast_osc_on_o && cpu_from_slow_o
        && !div_early_en_o && cpu_clk_en_o)
        else $error("lowclk run gates wrong");

    a_doze_release: assert property (
        mode_o == FAST_DUAL_DOZE && irq_request_i
        |=> mode_o == FAST_DUAL_RUN && !cpu_halt_o && cpu_clk_en_o)
        else $error("fast doze release wrong");

    a_doze_hold: assert property (
        mode_o == LOWCLK_ONLY_DOZE && !irq_request_i
        |=> mode_o == LOWCLK_ONLY_DOZE && !cpu_clk_en_o && !wdt_clk_en_o)
        else $error("low doze left without interrupt");

    a_tick_exit: assert property (
        mode_o == TICK_ONLY_DOZE && sif[SYNC_TICK].fall
        |=> mode_o == LOWCLK_ONLY_RUN && periph_clk_en_o && !timing_gen_halt_o)
        else $error("tick doze exit wrong");

    a_tick_irq_set: assert property (
        mode_o == TICK_ONLY_DOZE && sif[SYNC_TICK].fall && q.tick_armed
        |=> !tick_irq_set_o ##1 tick_irq_set_o)
        else $error("tick irq latch not set");

    a_tick_only: assert property (
        mode_o == TICK_ONLY_DOZE |-> tick_clk_en_o && !periph_clk_en_o
        && !cpu_clk_en_o)
        else $error("tick doze gates wrong");

    a_stop_halt: assert property (
        $rose(mode_o == STOP_HALT) |-> !fast_osc_on_o && !slow_osc_on_o
        && !tick_clk_en_o && !cpu_clk_en_o)
        else $error("stop mode not halted");

    a_warm_resume: assert property (
        mode_o == STOP_WARMUP && q.warm_cnt == '0
        |=> resume_o && mode_o == $past(q.ret_mode))
        else $error("resume after warm-up wrong");
endmodule
`default_nettype wire

// ===== verif/dcmc_tb.sv
// testbench for the dual clock mode controller: mode walks, doze, tick doze, stop
// assumes dcmc_pkg and the design files are compiled first; 200 MHz clock
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dcmc_pkg::*;
    // =========================================================
    // signals
    logic       clk_i, sys_rst_i, ctrl2_wr_i, msel, fosc, sosc, halt, tgh;
    logic       ctrl1_wr_i, stp, rlv, irq, pin, tsrc, tten, mien, ef;
    dcmc_mode_t mode, ret_m;
    logic       msel_o, halt_o, tgh_o, setp, takep, res;
    wire  [7:0] gates;
    int         fail_count, compares, cycles, n_set, n_take, n_res, s0, t0, i;
    logic [31:0] rs;

    dcmc_top #(.WARMUP_CYCLES(8)) dcmc_top_i (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ctrl2_wr_i(ctrl2_wr_i),
        .wr_main_clock_select_i(msel), .wr_fast_osc_enable_i(fosc),
        .wr_slow_osc_enable_i(sosc), .wr_cpu_halt_i(halt), .wr_timing_gen_halt_i(tgh),
        .ctrl1_wr_i(ctrl1_wr_i), .wr_stop_i(stp), .wr_release_level_i(rlv),
        .irq_request_i(irq), .stop_pin_i(pin), .tick_src_i(tsrc),
        .tick_timer_enable_i(tten), .master_interrupt_enable_i(mien),
        .tick_irq_enable_i(ef), .mode_o(mode), .main_clock_select_o(msel_o),
        .cpu_halt_o(halt_o), .timing_gen_halt_o(tgh_o), .fast_osc_on_o(gates[7]),
        .slow_osc_on_o(gates[6]), .cpu_from_slow_o(gates[5]), .cpu_clk_en_o(gates[4]),
        .wdt_clk_en_o(gates[3]), .tick_clk_en_o(gates[2]), .periph_clk_en_o(gates[1]),
        .div_early_en_o(gates[0]), .tick_irq_set_o(setp), .tick_irq_take_o(takep),
        .resume_o(res)
    );

    // =========================================================
    // clock, pulse counters, timeout
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (setp === 1'b1) n_set++;
        if (takep === 1'b1) n_take++;
        if (res === 1'b1) n_res++;
        if (cycles >= 4000) begin
            fail_count++;
            wrap_up();
        end
    end

    // =========================================================
    // helpers
    function automatic logic [31:0] xs();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    function automatic logic [7:0] exp_gates(input dcmc_mode_t m);
        logic [7:0] r;
        r = 8'h00;
        case (m)
            FAST_SINGLE_RUN:  r = 8'h9F;
            FAST_DUAL_RUN:    r = 8'hDF;
            SLOW_DUAL_RUN:    r = 8'hFF;
            LOWCLK_ONLY_RUN:  r = 8'h7E;
            FAST_DUAL_DOZE:   r = 8'hC7;
            SLOW_DUAL_DOZE:   r = 8'hE6;
            LOWCLK_ONLY_DOZE: r = 8'h66;
            TICK_ONLY_DOZE:   r = 8'h64;
            STOP_WARMUP:      r = exp_gates(ret_m) & 8'hC0;
            default:          r = 8'h00;
        endcase
        return r;
    endfunction
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic w2(input logic m, input logic f, input logic s, input logic h,
                      input logic t);
        @(negedge clk_i);
        {msel, fosc, sosc, halt, tgh} = {m, f, s, h, t};
        ctrl2_wr_i = 1'b1;
        @(negedge clk_i);
        ctrl2_wr_i = 1'b0;
    endtask
    task automatic w1(input logic s, input logic r);
        @(negedge clk_i);
        {stp, rlv} = {s, r};
        ctrl1_wr_i = 1'b1;
        @(negedge clk_i);
        ctrl1_wr_i = 1'b0;
    endtask
    task automatic go(input dcmc_mode_t m, input int lim);
        int k;
        k = 0;
        while (mode !== m && k < lim) begin
            @(negedge clk_i);
            k++;
        end
        chk("mode", {4'h0, m}, {4'h0, mode});
        chk("gates", exp_gates(m), gates);
    endtask
    task automatic doze(input logic m, input logic f, input dcmc_mode_t dz,
                        input dcmc_mode_t rn);
        w2(m, f, 1'b1, 1'b1, 1'b0);
        go(dz, 4);
        chk("cpu_halt", 8'h01, {7'h0, halt_o});
        repeat (xs() % 5) @(negedge clk_i);
        irq = 1'b1;
        @(negedge clk_i);
        irq = 1'b0;
        go(rn, 2);
        chk("cpu_halt", 8'h00, {7'h0, halt_o});
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // =========================================================
    // main sequence
    initial begin
        {ctrl2_wr_i, msel, fosc, sosc, halt, tgh, ctrl1_wr_i, stp, rlv} = '0;
        {irq, pin, tten, mien, ef} = '0;
        tsrc = 1'b1;
        sys_rst_i = 1'b1;
        rs = 32'd99218;
        {fail_count, compares, cycles, n_set, n_take, n_res} = '0;
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        sys_rst_i = 1'b0;
        chk("mode", 8'h00, {4'h0, mode});
        chk("gates", 8'h9F, gates);
        $display("test reset done");
        w2(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
        go(FAST_DUAL_RUN, 4);
        w2(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        go(SLOW_DUAL_RUN, 4);
        chk("msel", 8'h01, {7'h0, msel_o});
        w2(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        repeat (4) @(negedge clk_i);
        go(SLOW_DUAL_RUN, 0);
        w2(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        go(LOWCLK_ONLY_RUN, 4);
        w2(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        go(SLOW_DUAL_RUN, 4);
        w2(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
        go(FAST_DUAL_RUN, 4);
        w2(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        go(FAST_SINGLE_RUN, 4);
        w2(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
        go(FAST_DUAL_RUN, 4);
        $display("test run modes done");
        doze(1'b0, 1'b1, FAST_DUAL_DOZE, FAST_DUAL_RUN);
        w2(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        go(SLOW_DUAL_RUN, 4);
        doze(1'b1, 1'b1, SLOW_DUAL_DOZE, SLOW_DUAL_RUN);
        w2(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        go(LOWCLK_ONLY_RUN, 4);
        doze(1'b1, 1'b0, LOWCLK_ONLY_DOZE, LOWCLK_ONLY_RUN);
        $display("test doze done");
        for (i = 0; i < 4; i++) begin
            tten = i[0];
            mien = (i > 1) || (xs() % 2 == 1);
            ef = (i > 1) || (xs() % 2 == 1);
            s0 = n_set;
            t0 = n_take;
            w2(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
            go(TICK_ONLY_DOZE, 4);
            chk("tg_halt", 8'h01, {7'h0, tgh_o});
            repeat (6) @(negedge clk_i);
            go(TICK_ONLY_DOZE, 0);
            tsrc = 1'b0;
            go(LOWCLK_ONLY_RUN, 10);
            chk("tg_halt", 8'h00, {7'h0, tgh_o});
            repeat (4) @(negedge clk_i);
            tsrc = 1'b1;
            chk("irq_set", {7'h0, tten}, 8'(n_set - s0));
            chk("irq_take", {7'h0, tten & mien & ef}, 8'(n_take - t0));
        end
        $display("test tick doze done");
        for (i = 0; i < 2; i++) begin
            pin = 1'b0;
            ret_m = (i == 0) ? LOWCLK_ONLY_RUN : SLOW_DUAL_RUN;
            if (i == 1) begin
                w2(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
                go(SLOW_DUAL_RUN, 4);
            end
            w1(1'b1, i == 0);
            go(STOP_HALT, 3);
            repeat (5) @(negedge clk_i);
            go(STOP_HALT, 0);
            s0 = n_res;
            pin = 1'b1;
            go(STOP_WARMUP, 8);
            go(ret_m, 12);
            repeat (3) @(negedge clk_i);
            chk("resume", 8'h01, 8'(n_res - s0));
        end
        $display("test stop done");
        wrap_up();
    end
endmodule
`default_nettype wire
